// File: inc/alrd_pkg.sv
// package: opcode constants, field layout and decode types
package alrd_pkg;

  // opcode field positions
  localparam int ALRD_TOP_HI = 7;
  localparam int ALRD_TOP_LO = 6;
  localparam int ALRD_MID_HI = 5;
  localparam int ALRD_MID_LO = 3;
  localparam int ALRD_LOW_HI = 2;
  localparam int ALRD_LOW_LO = 0;
  localparam int ALRD_CARRY_VARIANT_BIT = 4;

  // group selectors in the top two bits
  localparam logic [1:0] ALRD_TOP_LOGIC = 2'h2;
  localparam logic [1:0] ALRD_TOP_IMM = 2'h3;

  // function codes in bits five to three of the logic group
  localparam logic [2:0] ALRD_FN_AND = 3'h4;
  localparam logic [2:0] ALRD_FN_XOR = 3'h5;
  localparam logic [2:0] ALRD_FN_OR = 3'h6;
  localparam logic [2:0] ALRD_FN_COMPARE = 3'h7;

  // operand field codes
  localparam logic [2:0] ALRD_FLD_B = 3'h0;
  localparam logic [2:0] ALRD_FLD_C = 3'h1;
  localparam logic [2:0] ALRD_FLD_D = 3'h2;
  localparam logic [2:0] ALRD_FLD_E = 3'h3;
  localparam logic [2:0] ALRD_FLD_H = 3'h4;
  localparam logic [2:0] ALRD_FLD_L = 3'h5;
  localparam logic [2:0] ALRD_FLD_MEMORY = 3'h6;
  localparam logic [2:0] ALRD_FLD_ACCUMULATOR = 3'h7;

  // whole opcodes
  localparam logic [7:0] ALRD_OPC_AND_IMM = 8'he6;
  localparam logic [7:0] ALRD_OPC_XOR_IMM = 8'hee;
  localparam logic [7:0] ALRD_OPC_OR_IMM = 8'hf6;
  localparam logic [7:0] ALRD_OPC_COMPARE_IMM = 8'hfe;
  localparam logic [7:0] ALRD_OPC_SUB_IMM_BORROW = 8'hde;
  localparam logic [7:0] ALRD_OPC_ROT_LEFT = 8'h07;
  localparam logic [7:0] ALRD_OPC_ROT_RIGHT = 8'h0f;
  localparam logic [7:0] ALRD_OPC_ROT_LEFT_CARRY = 8'h17;
  localparam logic [7:0] ALRD_OPC_ROT_RIGHT_CARRY = 8'h1f;
  localparam logic [7:0] ALRD_OPC_COMPLEMENT_ACC = 8'h2f;
  localparam logic [7:0] ALRD_OPC_CARRY_SET = 8'h37;
  localparam logic [7:0] ALRD_OPC_CARRY_COMPLEMENT = 8'h3f;
  localparam logic [7:0] ALRD_OPC_DECIMAL_ADJUST = 8'h27;
  localparam logic [7:0] ALRD_OPC_INTERRUPTS_ON = 8'hfb;
  localparam logic [7:0] ALRD_OPC_INTERRUPTS_OFF = 8'hf3;
  localparam logic [7:0] ALRD_OPC_NO_OPERATION = 8'h00;
  localparam logic [7:0] ALRD_OPC_HALT = 8'h76;
  localparam logic [7:0] ALRD_OPC_READ_INT_MASK = 8'h20;
  localparam logic [7:0] ALRD_OPC_SET_INT_MASK = 8'h30;

  // conditional return: 11 ccc 000
  localparam logic [2:0] ALRD_LOW_COND_RETURN = 3'h0;

  // execution lengths of condition dependent instructions
  localparam logic [3:0] ALRD_CYCLES_NOT_MET = 4'h6;
  localparam logic [3:0] ALRD_CYCLES_MET = 4'hc;
  localparam logic [3:0] ALRD_CYCLES_FIXED = 4'h0;

  // condition codes in bits five to three
  localparam logic [2:0] ALRD_CC_NOT_ZERO = 3'h0;
  localparam logic [2:0] ALRD_CC_ZERO = 3'h1;
  localparam logic [2:0] ALRD_CC_NO_CARRY = 3'h2;
  localparam logic [2:0] ALRD_CC_CARRY = 3'h3;
  localparam logic [2:0] ALRD_CC_PARITY_ODD = 3'h4;
  localparam logic [2:0] ALRD_CC_PARITY_EVEN = 3'h5;
  localparam logic [2:0] ALRD_CC_PLUS = 3'h6;
  localparam logic [2:0] ALRD_CC_MINUS = 3'h7;

  // decoded operation, one hot
  typedef enum logic [24:0] {
    OP_UNDECODED = 25'h0000001,
    OP_AND_WITH_ACCUMULATOR = 25'h0000002,
    OP_XOR_WITH_ACCUMULATOR = 25'h0000004,
    OP_OR_WITH_ACCUMULATOR = 25'h0000008,
    OP_COMPARE_WITH_ACCUMULATOR = 25'h0000010,
    OP_AND_IMMEDIATE = 25'h0000020,
    OP_XOR_IMMEDIATE = 25'h0000040,
    OP_OR_IMMEDIATE = 25'h0000080,
    OP_COMPARE_IMMEDIATE = 25'h0000100,
    OP_SUBTRACT_IMMEDIATE_BORROW = 25'h0000200,
    OP_ROTATE_LEFT_CIRCULAR = 25'h0000400,
    OP_ROTATE_RIGHT_CIRCULAR = 25'h0000800,
    OP_ROTATE_LEFT_VIA_CARRY = 25'h0001000,
    OP_ROTATE_RIGHT_VIA_CARRY = 25'h0002000,
    OP_COMPLEMENT_ACCUMULATOR = 25'h0004000,
    OP_CARRY_FLAG_SET = 25'h0008000,
    OP_COMPLEMENT_CARRY_FLAG = 25'h0010000,
    OP_DECIMAL_ADJUST = 25'h0020000,
    OP_INTERRUPTS_ON = 25'h0040000,
    OP_INTERRUPTS_OFF = 25'h0080000,
    OP_NO_OPERATION = 25'h0100000,
    OP_HALT_PROCESSOR = 25'h0200000,
    OP_READ_INTERRUPT_MASK = 25'h0400000,
    OP_SET_INTERRUPT_MASK = 25'h0800000,
    OP_CONDITIONAL_RETURN = 25'h1000000
  } alrd_op_t;

  // decoded operand source, one hot
  typedef enum logic [8:0] {
    SRC_NONE = 9'h001,
    SRC_B = 9'h002,
    SRC_C = 9'h004,
    SRC_D = 9'h008,
    SRC_E = 9'h010,
    SRC_H = 9'h020,
    SRC_L = 9'h040,
    SRC_MEMORY = 9'h080,
    SRC_ACCUMULATOR = 9'h100
  } alrd_src_t;

  // processor flags offered for condition tests
  typedef struct packed {
    logic sign;
    logic zero;
    logic parity;
    logic carry;
  } alrd_flags_t;

  // full decode result handed to fetch and execute
  typedef struct packed {
    alrd_op_t op;
    alrd_src_t source;
    logic [2:0] source_operand_field;
    logic memory_operand;
    logic immediate_byte;
    logic cond_dependent;
    logic cond_met;
    logic [3:0] cycles;
  } alrd_decode_t;

  localparam alrd_decode_t ALRD_DECODE_RESET = '{
    op: OP_NO_OPERATION, source: SRC_NONE, source_operand_field: 3'h0,
    memory_operand: 1'b0, immediate_byte: 1'b0, cond_dependent: 1'b0,
    cond_met: 1'b0, cycles: 4'h0};

endpackage

// File: verification/alrd_assertions.sv
// checker: decode latency and opcode mapping properties of the decoder
`timescale 1ns/1ps

module alrd_assertions (
  input wire logic sys_clk, // processor clock
  input wire logic rst, // synchronous reset
  input wire logic [7:0] opcode, // fetched byte
  input wire logic opcode_valid, // byte present
  input wire alrd_pkg::alrd_flags_t flags, // condition flags
  input wire alrd_pkg::alrd_decode_t decode_q, // decode result
  input wire logic decode_valid_q // result strobe
);
  import alrd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // reference condition: flags in condition-pair order, bit three
  // picks the polarity
  logic [3:0] flag_pick; // zero, carry, parity, sign from bit 0 up
  logic cond_ref; // the named condition holds on the live flags
  assign flag_pick = {flags.sign, flags.parity, flags.carry, flags.zero};
  assign cond_ref = flag_pick[opcode[5:4]] == opcode[3];

  // step one of every decode: a byte is taken
  sequence s_take;
    opcode_valid;
  endsequence
  // a taken byte of the register/memory logic group
  sequence s_logic;
    s_take ##0 opcode[7:6] == ALRD_TOP_LOGIC && opcode[5];
  endsequence
  // a taken accumulator rotate, left or right by bit three
  sequence s_rot(logic r);
    s_take ##0 opcode[7:5] == 3'h0 && opcode[3] == r && opcode[2:0] == 3'h7;
  endsequence
  // a taken conditional return
  sequence s_cond;
    s_take ##0 opcode[7:6] == 2'h3 && opcode[2:0] == ALRD_LOW_COND_RETURN;
  endsequence

  property p_valid;
    1'b1 |=> decode_valid_q == $past(opcode_valid);
  endproperty
  property p_field;
    s_logic |=> decode_q.source_operand_field == $past(opcode[2:0])
      && decode_q.source == alrd_src_t'(9'h002 << $past(opcode[2:0]));
  endproperty
  property p_func;
    s_logic |=> decode_q.op == alrd_op_t'(25'h2 << $past(opcode[4:3]));
  endproperty
  property p_mem;
    s_logic |=> decode_q.memory_operand == ($past(opcode[2:0]) == 3'h6);
  endproperty
  property p_imm;
    s_take ##0 opcode inside {8'he6, 8'hee, 8'hf6, 8'hfe, 8'hde}
      |=> decode_q.immediate_byte && !decode_q.memory_operand;
  endproperty
  property p_rot(logic r);
    s_rot(r) |=> decode_q.source == SRC_ACCUMULATOR && decode_q.op ==
      alrd_op_t'(25'h400 << {$past(opcode[4]), r});
  endproperty
  property p_cond;
    s_cond |=> decode_q.cond_dependent && decode_q.cycles ==
      (decode_q.cond_met ? ALRD_CYCLES_MET : ALRD_CYCLES_NOT_MET)
      && decode_q.cond_met == $past(cond_ref);
  endproperty
  property p_halt;
    s_take ##0 opcode == ALRD_OPC_HALT |=> decode_q.op == OP_HALT_PROCESSOR;
  endproperty

  a_valid: assert property (p_valid)
    else $error("result strobe does not follow the byte strobe");
  a_field: assert property (p_field)
    else $error("operand field decoded wrongly");
  a_func: assert property (p_func)
    else $error("logic function decoded wrongly");
  a_mem: assert property (p_mem)
    else $error("memory operand flag wrong");
  a_imm: assert property (p_imm)
    else $error("immediate opcode without immediate fetch");
  a_rot_left: assert property (p_rot(1'b0))
    else $error("left rotate decoded wrongly");
  a_rot_right: assert property (p_rot(1'b1))
    else $error("right rotate decoded wrongly");
  a_cond: assert property (p_cond)
    else $error("conditional length does not match condition");
  a_halt: assert property (p_halt)
    else $error("halt opcode decoded wrongly");
endmodule

bind alrd_decoder alrd_assertions u_chk (.sys_clk(sys_clk), .rst(rst),
  .opcode(opcode), .opcode_valid(opcode_valid), .flags(flags),
  .decode_q(decode_q), .decode_valid_q(decode_valid_q));

// File: verification/alrd_fetch_model.sv
// partner model: fetch side that offers opcode bytes and flags
`timescale 1ns/1ps

module alrd_fetch_model (
  output logic [7:0] opcode, // byte offered to the decoder
  output logic opcode_valid, // byte present this cycle
  output alrd_pkg::alrd_flags_t flags // current flags
);
  import alrd_pkg::*;

  // called just after a rising edge; holds until the next call
  // an idle byte lane shows the inverse of the last byte, so a
  // decoder that samples without the strobe sees a different opcode
  task automatic present(logic [7:0] c, logic v, alrd_flags_t f);
    opcode_valid = v;
    opcode = v ? c : ~opcode;
    flags = f;
  endtask

  // quiet lane at time zero
  initial begin
    opcode = 8'h00;
    opcode_valid = 1'b0;
    flags = '0;
  end
endmodule

// File: verification/testbench.sv
// testbench: opcode sweep against a reference decode model
`timescale 1ns/1ps

module testbench;
  import alrd_pkg::*;
  logic sys_clk = 1'b0; // processor clock
  logic rst = 1'b1; // reset, held at start
  logic [7:0] opcode; // byte from the fetch model
  logic opcode_valid; // byte strobe
  alrd_flags_t flags; // flags from the fetch model
  alrd_decode_t decode_q; // decode result
  logic decode_valid_q; // result strobe
  int fail_count = 0; // mismatches
  int comparisons = 0; // checks made
  int cycles = 0; // cycle count for the hang limit
  alrd_decode_t exp_q[$]; // expected results in flight
  alrd_decode_t last_e = ALRD_DECODE_RESET; // result that must hold

  alrd_decoder u_dut (.sys_clk(sys_clk), .rst(rst), .opcode(opcode),
    .opcode_valid(opcode_valid), .flags(flags), .decode_q(decode_q),
    .decode_valid_q(decode_valid_q));
  alrd_fetch_model u_fetch (.opcode(opcode), .opcode_valid(opcode_valid),
    .flags(flags));

  // 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;

  // reference decode written from the opcode tables
  function automatic alrd_decode_t model(logic [7:0] c, alrd_flags_t f);
    alrd_decode_t d;
    logic [3:0] fl;
    logic sel;
    d = ALRD_DECODE_RESET;
    d.op = OP_UNDECODED;
    d.source_operand_field = c[2:0];
    fl = {f.zero, f.carry, f.parity, f.sign};
    sel = fl[3 - c[5:4]];
    if (c[7:5] == 3'h5) begin
      d.op = alrd_op_t'(25'h2 << c[4:3]);
      d.source = alrd_src_t'(9'h002 << c[2:0]);
      d.memory_operand = c[2:0] == 3'h6;
    end else case (c)
      8'he6, 8'hee, 8'hf6, 8'hfe: d.op = alrd_op_t'(25'h20 << c[4:3]);
      8'hde: d.op = OP_SUBTRACT_IMMEDIATE_BORROW;
      8'h07, 8'h0f, 8'h17, 8'h1f: d.op = alrd_op_t'(25'h400 << c[4:3]);
      8'h2f: d.op = OP_COMPLEMENT_ACCUMULATOR;
      8'h37: d.op = OP_CARRY_FLAG_SET;
      8'h3f: d.op = OP_COMPLEMENT_CARRY_FLAG;
      8'h27: d.op = OP_DECIMAL_ADJUST;
      8'hfb: d.op = OP_INTERRUPTS_ON;
      8'hf3: d.op = OP_INTERRUPTS_OFF;
      8'h00: d.op = OP_NO_OPERATION;
      8'h76: d.op = OP_HALT_PROCESSOR;
      8'h20: d.op = OP_READ_INTERRUPT_MASK;
      8'h30: d.op = OP_SET_INTERRUPT_MASK;
      default: if (c[7:6] == 2'h3 && c[2:0] == 3'h0) begin
        d.op = OP_CONDITIONAL_RETURN;
        d.cond_dependent = 1'b1;
        d.cond_met = sel == c[3];
        d.cycles = d.cond_met ? 4'hc : 4'h6;
      end
    endcase
    d.immediate_byte = c inside {8'he6, 8'hee, 8'hf6, 8'hfe, 8'hde};
    if (c inside {8'h07, 8'h0f, 8'h17, 8'h1f, 8'h2f, 8'h27, 8'h30})
      d.source = SRC_ACCUMULATOR;
    return d;
  endfunction

  // one comparison, reported at once on mismatch
  task automatic check(string n, logic [24:0] e, logic [24:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // offer one byte, then check the result one edge later
  task automatic step(logic [7:0] c, logic v, alrd_flags_t f);
    alrd_decode_t e;
    alrd_decode_t g;
    u_fetch.present(c, v, f);
    if (v) exp_q.push_back(model(c, f));
    @(posedge sys_clk);
    #1;
    check("valid", 25'(v), 25'(decode_valid_q));
    if (v) last_e = exp_q.pop_front();
    e = last_e;
    g = decode_q;
    check("op", e.op, g.op);
    check("source", 25'(e.source), 25'(g.source));
    check("mem", 25'(e.memory_operand), 25'(g.memory_operand));
    check("imm", 25'(e.immediate_byte), 25'(g.immediate_byte));
    check("cycles", 25'(e.cycles), 25'(g.cycles));
    check("dep", 25'(e.cond_dependent), 25'(g.cond_dependent));
    check("met", 25'(e.cond_met), 25'(g.cond_met));
    check("field", 25'(e.source_operand_field),
      25'(g.source_operand_field));
  endtask

  task finish_test;
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang limit, well above the roughly 800 cycles of the run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test;
    end
  end

  initial begin
    void'($urandom(60082));
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    step(8'h00, 1'b0, '0);
    // every opcode back to back, random flags
    for (int i = 0; i < 256; i++)
      step(i[7:0], 1'b1, alrd_flags_t'(4'($urandom)));
    // each condition code against every flag pattern
    for (int i = 0; i < 128; i++)
      step({2'h3, i[2:0], 3'h0}, 1'b1, alrd_flags_t'(i[6:3]));
    // reset in mid-run with the byte strobe low
    rst = 1'b1;
    last_e = ALRD_DECODE_RESET;
    step(8'h76, 1'b0, '0);
    rst = 1'b0;
    step(8'h00, 1'b0, '0);
    // random bytes with gaps, result must hold over gaps
    for (int i = 0; i < 400; i++)
      step(8'($urandom), 1'($urandom), alrd_flags_t'(4'($urandom)));
    finish_test;
  end
endmodule

// File: verilog/alrd_cond_eval.sv
// condition test: flag check for condition dependent instructions
`timescale 1ns/1ps

module alrd_cond_eval (
  input wire logic [2:0] cond_code, // condition field, bits five to three
  input wire alrd_pkg::alrd_flags_t flags, // current processor flags
  output logic met // tested condition holds
);
  import alrd_pkg::*;

  // pick the flag named by the code, then its polarity
  always_comb begin
    case (cond_code)
      ALRD_CC_NOT_ZERO: met = ~flags.zero;
      ALRD_CC_ZERO: met = flags.zero;
      ALRD_CC_NO_CARRY: met = ~flags.carry;
      ALRD_CC_CARRY: met = flags.carry;
      ALRD_CC_PARITY_ODD: met = ~flags.parity;
      ALRD_CC_PARITY_EVEN: met = flags.parity;
      ALRD_CC_PLUS: met = ~flags.sign;
      ALRD_CC_MINUS: met = flags.sign;
      default: met = 1'b0;
    endcase
  end

endmodule

// File: verilog/alrd_decoder.sv
// decoder for logical, compare, rotate and control opcodes
//
// Operation
// - operand field 000-111 maps B..L, memory, accumulator
// - top bits 10: bits 5:3 function, low source
// - AND/XOR/OR/compare with low bits 110 fetch operand from memory
// - E6/EE/F6/FE immediates; DE subtract immediate borrow
// - 07 left rotate, 17 through carry
// - 0F right rotate, 1F through carry
// - conditional instructions take 6 or 12 cycles
`timescale 1ns/1ps

module alrd_decoder (
  input wire logic sys_clk, // processor clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] opcode, // fetched opcode byte
  input wire logic opcode_valid, // opcode byte present this cycle
  input wire alrd_pkg::alrd_flags_t flags, // flags for condition tests
  output alrd_pkg::alrd_decode_t decode_q, // registered decode result
  output logic decode_valid_q // decode_q belongs to a new opcode
);
  import alrd_pkg::*;

  // decode outline, one byte per valid cycle:
  //   10 fff rrr  logic group; fff picks the function, rrr the source
  //   11 ccc 000  conditional return; its length follows one flag
  //   anything else is matched as a whole byte or left undecoded
  // the result leaves one edge after the byte is taken; there is no
  // back-pressure, so a byte offered every cycle is decoded every cycle
  // the immediate operand itself is not taken here: immediate_byte only
  // tells the fetcher that one more byte belongs to this instruction
  // undecoded bytes belong to other groups and are left to other logic

  // operand field to one-hot source, used only for the source field
  function automatic alrd_src_t field_to_src(input logic [2:0] fld);
    alrd_src_t s;
    s = SRC_NONE;
    case (fld)
      ALRD_FLD_B: s = SRC_B;
      ALRD_FLD_C: s = SRC_C;
      ALRD_FLD_D: s = SRC_D;
      ALRD_FLD_E: s = SRC_E;
      ALRD_FLD_H: s = SRC_H;
      ALRD_FLD_L: s = SRC_L;
      ALRD_FLD_MEMORY: s = SRC_MEMORY;
      ALRD_FLD_ACCUMULATOR: s = SRC_ACCUMULATOR;
      // every code is listed; the default guards unknown input bits
      default: s = SRC_NONE;
    endcase
    return s;
  endfunction

  // opcode field slices
  logic [1:0] top_bits; // group selector
  logic [2:0] mid_bits; // function or condition field
  logic [2:0] low_bits; // source operand field
  logic cond_met; // condition evaluated on live flags

  // slice positions live in the package, so a remap touches one place
  assign top_bits = opcode[ALRD_TOP_HI:ALRD_TOP_LO];
  assign mid_bits = opcode[ALRD_MID_HI:ALRD_MID_LO];
  assign low_bits = opcode[ALRD_LOW_HI:ALRD_LOW_LO];

  // the condition is judged on the flags of the decode cycle; a flag
  // that changes one cycle later does not alter the stored length
  // the evaluator is a module of its own so the flag map has one home
  // flags come from the same clock domain, so no synchroniser here
  alrd_cond_eval u_cond (
    .cond_code(mid_bits),
    .flags(flags),
    .met(cond_met)
  );

  // next-state values
  // both are read only by the hold mux and the register stage
  alrd_decode_t decode_d; // decode result for the byte on opcode
  logic decode_valid_d; // valid flag next value

  // combinational decode of the present byte
  always_comb begin
    // start from the quiet result so every field is set on every path
    decode_d = ALRD_DECODE_RESET;
    decode_d.op = OP_UNDECODED;
    // the field passes through for every opcode; fetch ignores it
    // when the operation names no register
    decode_d.source_operand_field = low_bits;
    // cycles stays zero unless the opcode is condition dependent
    decode_d.cycles = ALRD_CYCLES_FIXED;
    if (top_bits == ALRD_TOP_LOGIC) begin
      // register, memory or accumulator form of the logic group
      decode_d.source = field_to_src(low_bits);
      // the memory form costs one extra bus read, keyed on this flag
      decode_d.memory_operand = (low_bits == ALRD_FLD_MEMORY);
      case (mid_bits)
        ALRD_FN_AND: decode_d.op = OP_AND_WITH_ACCUMULATOR;
        ALRD_FN_XOR: decode_d.op = OP_XOR_WITH_ACCUMULATOR;
        ALRD_FN_OR: decode_d.op = OP_OR_WITH_ACCUMULATOR;
        ALRD_FN_COMPARE: begin
          decode_d.op = OP_COMPARE_WITH_ACCUMULATOR;
        end
        default: begin
          // arithmetic codes live in another block; stay undecoded
          decode_d.op = OP_UNDECODED;
          decode_d.source = SRC_NONE;
          decode_d.memory_operand = 1'b0;
        end
      endcase
    end else if (top_bits == ALRD_TOP_IMM &&
                 low_bits == ALRD_LOW_COND_RETURN) begin
      // condition dependent: length follows the tested flag
      decode_d.op = OP_CONDITIONAL_RETURN;
      // the condition field shares bits five to three with the function
      // both lengths are package constants; fetch counts them down
      decode_d.cond_dependent = 1'b1;
      decode_d.cond_met = cond_met;
      decode_d.cycles = cond_met ? ALRD_CYCLES_MET
                                 : ALRD_CYCLES_NOT_MET;
    end else begin
      // whole-byte matches for immediates, rotates and controls
      case (opcode)
        // immediate forms: a second byte follows the opcode
        ALRD_OPC_AND_IMM: begin
          decode_d.op = OP_AND_IMMEDIATE;
          decode_d.immediate_byte = 1'b1;
        end
        ALRD_OPC_XOR_IMM: begin
          decode_d.op = OP_XOR_IMMEDIATE;
          decode_d.immediate_byte = 1'b1;
        end
        ALRD_OPC_OR_IMM: begin
          decode_d.op = OP_OR_IMMEDIATE;
          decode_d.immediate_byte = 1'b1;
        end
        ALRD_OPC_COMPARE_IMM: begin
          decode_d.op = OP_COMPARE_IMMEDIATE;
          decode_d.immediate_byte = 1'b1;
        end
        // subtract with borrow is the one arithmetic form decoded here
        ALRD_OPC_SUB_IMM_BORROW: begin
          decode_d.op = OP_SUBTRACT_IMMEDIATE_BORROW;
          decode_d.immediate_byte = 1'b1;
        end
        // accumulator rotates, circular or through the carry flag
        ALRD_OPC_ROT_LEFT, ALRD_OPC_ROT_LEFT_CARRY: begin
          // bit four picks the through-carry variant
          decode_d.source = SRC_ACCUMULATOR;
          decode_d.op = opcode[ALRD_CARRY_VARIANT_BIT]
                        ? OP_ROTATE_LEFT_VIA_CARRY
                        : OP_ROTATE_LEFT_CIRCULAR;
        end
        ALRD_OPC_ROT_RIGHT, ALRD_OPC_ROT_RIGHT_CARRY: begin
          // bit four again picks the through-carry variant
          decode_d.source = SRC_ACCUMULATOR;
          decode_d.op = opcode[ALRD_CARRY_VARIANT_BIT]
                        ? OP_ROTATE_RIGHT_VIA_CARRY
                        : OP_ROTATE_RIGHT_CIRCULAR;
        end
        // accumulator and carry flag operations without an operand
        ALRD_OPC_COMPLEMENT_ACC: begin
          decode_d.op = OP_COMPLEMENT_ACCUMULATOR;
          decode_d.source = SRC_ACCUMULATOR;
        end
        ALRD_OPC_CARRY_SET: decode_d.op = OP_CARRY_FLAG_SET;
        ALRD_OPC_CARRY_COMPLEMENT: begin
          decode_d.op = OP_COMPLEMENT_CARRY_FLAG;
        end
        ALRD_OPC_DECIMAL_ADJUST: begin
          decode_d.op = OP_DECIMAL_ADJUST;
          decode_d.source = SRC_ACCUMULATOR;
        end
        // interrupt control and machine control
        ALRD_OPC_INTERRUPTS_ON: decode_d.op = OP_INTERRUPTS_ON;
        ALRD_OPC_INTERRUPTS_OFF: begin
          decode_d.op = OP_INTERRUPTS_OFF;
        end
        ALRD_OPC_NO_OPERATION: decode_d.op = OP_NO_OPERATION;
        ALRD_OPC_HALT: decode_d.op = OP_HALT_PROCESSOR;
        // mask transfers: the set form reads the accumulator
        ALRD_OPC_READ_INT_MASK: begin
          decode_d.op = OP_READ_INTERRUPT_MASK;
        end
        ALRD_OPC_SET_INT_MASK: begin
          decode_d.op = OP_SET_INTERRUPT_MASK;
          decode_d.source = SRC_ACCUMULATOR;
        end
        // arithmetic, move, branch and stack codes land here
        default: decode_d.op = OP_UNDECODED; // other groups
      endcase
    end
    // the strobe follows the byte strobe alone; reset clears it below
    decode_valid_d = opcode_valid;
  end

  // trade-off: the hold costs a mux on every result bit but spares
  // the datapath a capture register of its own
  // a byte offered with the strobe low is ignored, whatever it shows
  // register stage; result holds when no new byte arrives so the
  // datapath may sample it late without a hold register of its own
  alrd_decode_t hold_d; // value actually loaded
  always_comb begin
    hold_d = opcode_valid ? decode_d : decode_q;
  end

  // registers only; reset wins over a byte offered in the same cycle,
  // so that byte is lost and fetch must offer it again
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      decode_q <= ALRD_DECODE_RESET;
      decode_valid_q <= 1'b0;
    end else begin
      // load the held or the fresh result
      decode_q <= hold_d;
      decode_valid_q <= decode_valid_d;
    end
  end

  // limitation: the decoder sees one byte at a time and keeps no
  // knowledge of instruction boundaries; a data byte offered with the
  // strobe high is decoded as if it were an opcode, so the fetcher must
  // raise opcode_valid only on the first byte of each instruction
  // and keep it low on the bytes that follow

endmodule
